/* dtam_history.sv */
// Six-record fault history, newest first, with registered read port
`timescale 1ns/1ns
`default_nettype none
module dtam_history
  import dtam_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Record push
  input wire logic push_i,
  input wire logic [DTAM_ENTRY_W-1:0] push_entry_i,
  // Read port
  input wire logic [2:0] rd_idx_i,
  output logic [DTAM_ENTRY_W-1:0] rd_entry_o
);
  typedef struct packed
  {
    logic [DTAM_HIST_DEPTH-1:0][DTAM_ENTRY_W-1:0] ents; // Record 0 is the newest
    logic [DTAM_ENTRY_W-1:0] rd; // Registered read data
  } dtam_hist_t;
  dtam_hist_t h_reg;
  dtam_hist_t h_next;
  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    h_next = h_reg;
    // Shift back, oldest falls off, newest enters record 0
    if (push_i)
    begin
      for (int i = DTAM_HIST_DEPTH-1; i > 0; i--)
        h_next.ents[i] = h_reg.ents[i-1];
      h_next.ents[0] = push_entry_i;
    end
    // Out-of-range index reads as zero
    if (rd_idx_i < 3'(DTAM_HIST_DEPTH))
      h_next.rd = h_reg.ents[rd_idx_i];
    else
      h_next.rd = '0;
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      h_reg <= '0;
    else
      h_reg <= h_next;
  end
  assign rd_entry_o = h_reg.rd;
  // ****************************************
  // Checks
  // ****************************************
  newest_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i |=> h_reg.ents[0] == $past(push_entry_i)) else $error("newest record not in slot 0");
  shift_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i |=> h_reg.ents[5] == $past(h_reg.ents[4]) && h_reg.ents[1] == $past(h_reg.ents[0]))
    else $error("history did not shift");
endmodule // dtam_history
`default_nettype wire

/* dtam_manager.sv */
// Drive trip and alarm manager: trip state, resets, snapshot, history and Wishbone registers
`timescale 1ns/1ns
`default_nettype none
module dtam_manager
  import dtam_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Protective conditions
  input wire logic err_req_i,
  input wire logic [7:0] err_code_i,
  input wire logic err_lock_i,
  // Operating values
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] current_sensor_i,
  input wire logic [15:0] dc_bus_i,
  input wire dtam_phase_t phase_i,
  // Operator and terminals
  input wire logic stop_key_i,
  input wire logic [7:0] multi_input_i,
  // Drive and alarm outputs
  output logic power_enable_o,
  output logic alarm_led_o,
  output logic [7:0] alarm_code_o,
  output logic irq_o
);
  typedef enum logic {DTAM_ST_RUN, DTAM_ST_TRIP} dtam_state_t;
  typedef struct packed
  {
    dtam_state_t state; // Run or tripped
    logic lock; // Trip needs a power cycle
    logic [7:0] code; // Shown alarm code
    logic [15:0] snap_freq; // Trip-time values
    logic [15:0] snap_cur;
    logic [15:0] snap_bus;
    logic key_prev; // For key press edge
    logic [7:0] in_prev; // For input edges
    logic [1:0] stop_key_select; // Key selection field
    logic [31:0] func_lo; // Input 1..4 functions
    logic [31:0] func_hi; // Input 5..8 functions
    logic [15:0] rated; // Rated output current
    logic [1:0] irq_stat; // Sticky events
    logic [1:0] irq_mask; // Event enables
    logic [2:0] hist_sel; // History read index
    logic push; // History push strobe
    logic ack; // Bus answer
    logic [31:0] dat; // Bus read data
    logic power; // Power stage enable
    logic irq; // Interrupt level
  } dtam_mgr_t;
  dtam_mgr_t r_reg;
  dtam_mgr_t r_next;
  logic oc_trip; // Overcurrent seen
  logic [7:0] oc_code; // Phase-classified code
  logic [DTAM_ENTRY_W-1:0] hist_rd; // Selected history record
  logic [7:0] rs_hit; // Inputs acting as trip reset
  logic key_press; // Stop key rising edge
  logic key_reset; // Key allowed to reset
  logic rs_reset; // Terminal reset edge
  logic trip_now; // A new trip this cycle
  logic [7:0] trip_code; // Code of the new trip
  logic bus_req; // New bus request
  logic bus_wr; // Write takes effect now
  // ****************************************
  // Helper functions
  // ****************************************
  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction
  // Function field of input n
  function automatic logic [7:0] input_func(input logic [31:0] lo, input logic [31:0] hi, input int n);
    logic [63:0] all;
    all = {hi, lo};
    return all[8*n +: 8];
  endfunction
  // ****************************************
  // Sub-blocks
  // ****************************************
  // Overcurrent detection and classification
  dtam_overcurrent u_oc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .current_i(current_sensor_i),
    .rated_i(r_reg.rated),
    .phase_i(phase_i),
    .oc_o(oc_trip),
    .code_o(oc_code)
  );
  // Fault history store
  dtam_history u_hist
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(r_reg.push),
    .push_entry_i({r_reg.code, r_reg.snap_freq, r_reg.snap_cur, r_reg.snap_bus}),
    .rd_idx_i(r_reg.hist_sel),
    .rd_entry_o(hist_rd)
  );
  // ****************************************
  // Reset sources
  // ****************************************
  // Each terminal whose function is the reset function
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rs
      assign rs_hit[gi] = (input_func(r_reg.func_lo, r_reg.func_hi, gi) == DTAM_FUNC_RESET)
                          && multi_input_i[gi] && !r_reg.in_prev[gi];
    end
  endgenerate
  assign key_press = stop_key_i && !r_reg.key_prev;
  assign key_reset = key_press && (r_reg.stop_key_select == DTAM_KEY_FULL
                     || r_reg.stop_key_select == DTAM_KEY_RESET_ONLY);
  assign rs_reset = |rs_hit;
  // External errors win over a simultaneous overcurrent
  assign trip_now = (r_reg.state == DTAM_ST_RUN) && (err_req_i || oc_trip);
  assign trip_code = err_req_i ? err_code_i : oc_code;
  // Write lands on the edge where the master sees ack
  assign bus_req = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack;
  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.key_prev = stop_key_i;
    r_next.in_prev = multi_input_i;
    r_next.push = 1'b0;
    // Trip sequencing
    unique case (r_reg.state)
      DTAM_ST_RUN:
      begin
        if (trip_now)
        begin
          r_next.state = DTAM_ST_TRIP;
          r_next.code = trip_code;
          r_next.lock = err_req_i && err_lock_i;
          r_next.snap_freq = out_freq_i;
          r_next.snap_cur = current_sensor_i;
          r_next.snap_bus = dc_bus_i;
          r_next.push = 1'b1;
        end
      end
      DTAM_ST_TRIP:
      begin
        // Locked trips ignore both reset paths
        if (!r_reg.lock && (key_reset || rs_reset))
        begin
          r_next.state = DTAM_ST_RUN;
          r_next.code = 8'h00;
        end
      end
    endcase
    r_next.power = (r_next.state == DTAM_ST_RUN);
    // Bus write; hardware set wins over a simultaneous clear
    r_next.ack = bus_req;
    if (bus_wr)
    begin
      unique case (wb_adr_i)
        DTAM_OFS_CONFIG:
          r_next.stop_key_select = wb_sel_i[0] ? wb_dat_i[1:0] : r_reg.stop_key_select;
        DTAM_OFS_FUNC_LO: r_next.func_lo = lane_merge(r_reg.func_lo, wb_dat_i, wb_sel_i);
        DTAM_OFS_FUNC_HI: r_next.func_hi = lane_merge(r_reg.func_hi, wb_dat_i, wb_sel_i);
        DTAM_OFS_RATED:
          r_next.rated = 16'(lane_merge({16'h0000, r_reg.rated}, wb_dat_i, wb_sel_i));
        DTAM_OFS_IRQ_STAT:
          r_next.irq_stat = wb_sel_i[0] ? (r_reg.irq_stat & ~wb_dat_i[1:0]) : r_reg.irq_stat;
        DTAM_OFS_IRQ_MASK: r_next.irq_mask = wb_sel_i[0] ? wb_dat_i[1:0] : r_reg.irq_mask;
        DTAM_OFS_HIST_SEL: r_next.hist_sel = wb_sel_i[0] ? wb_dat_i[2:0] : r_reg.hist_sel;
        default: r_next.ack = bus_req; // Unmapped writes are dropped
      endcase
    end
    // Event capture
    if (trip_now)
      r_next.irq_stat[DTAM_IRQ_TRIP_BIT] = 1'b1;
    if (r_reg.state == DTAM_ST_TRIP && r_next.state == DTAM_ST_RUN)
      r_next.irq_stat[DTAM_IRQ_CLEAR_BIT] = 1'b1;
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
    // Bus read data, valid while ack is high; unmapped reads zero
    r_next.dat = 32'h0000_0000;
    if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        DTAM_OFS_CONFIG: r_next.dat = {30'h0000_0000, r_reg.stop_key_select};
        DTAM_OFS_FUNC_LO: r_next.dat = r_reg.func_lo;
        DTAM_OFS_FUNC_HI: r_next.dat = r_reg.func_hi;
        DTAM_OFS_RATED: r_next.dat = {16'h0000, r_reg.rated};
        DTAM_OFS_STATUS:
        begin
          r_next.dat[DTAM_STAT_TRIP_BIT] = (r_reg.state == DTAM_ST_TRIP);
          r_next.dat[DTAM_STAT_LOCK_BIT] = r_reg.lock;
          r_next.dat[DTAM_STAT_CODE_LSB +: 8] = r_reg.code;
        end
        DTAM_OFS_IRQ_STAT: r_next.dat = {30'h0000_0000, r_reg.irq_stat};
        DTAM_OFS_IRQ_MASK: r_next.dat = {30'h0000_0000, r_reg.irq_mask};
        DTAM_OFS_SNAP_FREQ: r_next.dat = {16'h0000, r_reg.snap_freq};
        DTAM_OFS_SNAP_CUR: r_next.dat = {16'h0000, r_reg.snap_cur};
        DTAM_OFS_SNAP_BUS: r_next.dat = {16'h0000, r_reg.snap_bus};
        DTAM_OFS_HIST_SEL: r_next.dat = {29'h0000_0000, r_reg.hist_sel};
        DTAM_OFS_HIST_A: r_next.dat = {8'h00, hist_rd[55:32]};
        DTAM_OFS_HIST_B: r_next.dat = hist_rd[31:0];
        default: r_next.dat = 32'h0000_0000;
      endcase
    end
  end
  // ****************************************
  // State register
  // ****************************************
  // Lock clears only here, at power-on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg <= '0;
      r_reg.state <= DTAM_ST_RUN;
      r_reg.power <= 1'b1;
      r_reg.stop_key_select <= DTAM_CONFIG_RST;
      r_reg.func_lo <= DTAM_FUNC_RST;
      r_reg.func_hi <= DTAM_FUNC_RST;
      r_reg.rated <= DTAM_RATED_RST;
      r_reg.irq_mask <= DTAM_IRQ_MASK_RST;
    end
    else
      r_reg <= r_next;
  end
  // Outputs straight from flip-flops
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign power_enable_o = r_reg.power;
  assign alarm_led_o = (r_reg.state == DTAM_ST_TRIP);
  assign alarm_code_o = r_reg.code;
  assign irq_o = r_reg.irq;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  trip_outputs_a: assert property (
    alarm_led_o |-> !power_enable_o && alarm_code_o != 8'h00)
    else $error("trip without output off");
  trip_entry_a: assert property (
    (r_reg.state == DTAM_ST_RUN && err_req_i) |=> alarm_led_o && alarm_code_o == $past(err_code_i))
    else $error("error did not trip");
  snap_value_a: assert property (
    $rose(alarm_led_o) |-> r_reg.snap_freq == $past(out_freq_i) && r_reg.snap_bus == $past(dc_bus_i))
    else $error("snapshot mismatch");
  key_ignored_a: assert property (
    (alarm_led_o && key_press && r_reg.stop_key_select[0] && !rs_reset) |=> alarm_led_o)
    else $error("key reset with disabled selection");
  key_clears_a: assert property (
    (alarm_led_o && !r_reg.lock && key_press && r_reg.stop_key_select == DTAM_KEY_RESET_ONLY)
    |=> !alarm_led_o ##0 power_enable_o) else $error("key reset not taken");
  term_clears_a: assert property (
    (alarm_led_o && !r_reg.lock && multi_input_i[7] && !r_reg.in_prev[7]
     && r_reg.func_hi[31:24] == DTAM_FUNC_RESET) |=> !alarm_led_o) else $error("terminal reset not taken");
  lock_hold_a: assert property (
    (alarm_led_o && r_reg.lock) |=> alarm_led_o [*2]) else $error("locked trip was reset");
  push_once_a: assert property (
    r_reg.push |=> !r_reg.push && alarm_led_o) else $error("history push not single");
  bus_ack_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
  irq_level_a: assert property (
    $rose(r_reg.irq_stat[DTAM_IRQ_TRIP_BIT]) && r_reg.irq_mask[DTAM_IRQ_TRIP_BIT] |-> irq_o)
    else $error("irq not raised");
  trip_cover_c: cover property ($rose(alarm_led_o));
  oc_trip_cover_c: cover property (!alarm_led_o && oc_trip && !err_req_i ##1 alarm_led_o);
  key_reset_cover_c: cover property (alarm_led_o && key_reset ##1 !alarm_led_o);
  rs_reset_cover_c: cover property (alarm_led_o && rs_reset && !r_reg.lock ##1 !alarm_led_o);
endmodule // dtam_manager
`default_nettype wire

/* dtam_operator_model.sv */
// Behavioural model of the front-panel operator and the control input terminals
`timescale 1ns/1ns
`default_nettype none
module dtam_operator_model
(
  // Clock
  input wire logic clk_i,
  // Key and terminals toward the block
  output logic stop_key_o,
  output logic [7:0] multi_input_o
);
  // ****************************************
  // Operator actions
  // ****************************************
  // Idle: nothing pressed, every terminal off
  initial
  begin
    stop_key_o = 1'b0;
    multi_input_o = 8'h00;
  end
  // Key held two cycles so that a rising edge is seen, then released
  task automatic press_key();
    @(posedge clk_i);
    stop_key_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    stop_key_o <= 1'b0;
  endtask
  // Controller asserts one terminal briefly to ask for a reset
  task automatic pulse_input(input int n);
    @(posedge clk_i);
    multi_input_o[n] <= 1'b1;
    repeat (2) @(posedge clk_i);
    multi_input_o[n] <= 1'b0;
  endtask
endmodule // dtam_operator_model
`default_nettype wire

/* dtam_overcurrent.sv */
// Overcurrent detector classifying the trip by operating phase
`timescale 1ns/1ns
`default_nettype none
module dtam_overcurrent
  import dtam_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Measurements
  input wire logic [15:0] current_i,
  input wire logic [15:0] rated_i,
  input wire dtam_phase_t phase_i,
  // Result, one cycle after the sample
  output logic oc_o,
  output logic [7:0] code_o
);
  typedef struct packed
  {
    logic oc;
    logic [7:0] code;
  } dtam_oc_t;
  dtam_oc_t o_reg;
  dtam_oc_t o_next;
  logic [23:0] cur_scaled;
  logic [23:0] lim_scaled;
  // Compare current*100 with rated*220, no divider needed
  // Operands widened first so the products never wrap at 16 bits
  assign cur_scaled = 24'(current_i) * 24'(DTAM_PERCENT_FULL);
  assign lim_scaled = 24'(rated_i) * 24'(DTAM_OC_PERCENT);
  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    o_next.oc = cur_scaled >= lim_scaled;
    // Code follows the phase seen at detection
    unique case (phase_i)
      DTAM_PH_CONST: o_next.code = DTAM_OC_CONST_CODE;
      DTAM_PH_DECEL: o_next.code = DTAM_OC_DECEL_CODE;
      DTAM_PH_ACCEL: o_next.code = DTAM_OC_ACCEL_CODE;
      DTAM_PH_OTHER: o_next.code = DTAM_OC_OTHER_CODE;
    endcase
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      o_reg <= '0;
    else
      o_reg <= o_next;
  end
  assign oc_o = o_reg.oc;
  assign code_o = o_reg.code;
  // ****************************************
  // Checks
  // ****************************************
  oc_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (32'(current_i) * 100 >= 32'(rated_i) * 220) |=> oc_o) else $error("overcurrent missed");
  oc_accel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (phase_i == DTAM_PH_ACCEL) |=> code_o == DTAM_OC_ACCEL_CODE) else $error("wrong accel code");
endmodule // dtam_overcurrent
`default_nettype wire

/* dtam_pkg.sv */
// Package of constants and types for the drive trip and alarm manager
package dtam_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] DTAM_OFS_CONFIG = 8'h00; // Stop key selection
  localparam logic [7:0] DTAM_OFS_FUNC_LO = 8'h04; // Input 1..4 function selects
  localparam logic [7:0] DTAM_OFS_FUNC_HI = 8'h08; // Input 5..8 function selects
  localparam logic [7:0] DTAM_OFS_RATED = 8'h0C; // Rated output current
  localparam logic [7:0] DTAM_OFS_STATUS = 8'h10; // Trip state, lock, code
  localparam logic [7:0] DTAM_OFS_IRQ_STAT = 8'h14; // Sticky events, write one to clear
  localparam logic [7:0] DTAM_OFS_IRQ_MASK = 8'h18; // Event enables
  localparam logic [7:0] DTAM_OFS_SNAP_FREQ = 8'h1C; // Trip-time output frequency
  localparam logic [7:0] DTAM_OFS_SNAP_CUR = 8'h20; // Trip-time output current
  localparam logic [7:0] DTAM_OFS_SNAP_BUS = 8'h24; // Trip-time DC bus voltage
  localparam logic [7:0] DTAM_OFS_HIST_SEL = 8'h28; // History record index
  localparam logic [7:0] DTAM_OFS_HIST_A = 8'h2C; // Record code and frequency
  localparam logic [7:0] DTAM_OFS_HIST_B = 8'h30; // Record current and bus voltage
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int DTAM_STAT_TRIP_BIT = 0;
  localparam int DTAM_STAT_LOCK_BIT = 1;
  localparam int DTAM_STAT_CODE_LSB = 8;
  localparam int DTAM_IRQ_TRIP_BIT = 0;
  localparam int DTAM_IRQ_CLEAR_BIT = 1;
  localparam logic [1:0] DTAM_CONFIG_RST = 2'h0;
  localparam logic [31:0] DTAM_FUNC_RST = 32'h0000_0000;
  localparam logic [15:0] DTAM_RATED_RST = 16'hFFFF;
  localparam logic [1:0] DTAM_IRQ_MASK_RST = 2'h0;
  // ****************************************
  // Codes and selections
  // ****************************************
  localparam logic [1:0] DTAM_KEY_FULL = 2'h0; // Stop and reset enabled
  localparam logic [1:0] DTAM_KEY_RESET_ONLY = 2'h2; // Only reset enabled
  localparam logic [7:0] DTAM_FUNC_RESET = 8'd18; // Input acts as trip reset
  localparam logic [7:0] DTAM_OC_CONST_CODE = 8'h01;
  localparam logic [7:0] DTAM_OC_DECEL_CODE = 8'h02;
  localparam logic [7:0] DTAM_OC_ACCEL_CODE = 8'h03;
  localparam logic [7:0] DTAM_OC_OTHER_CODE = 8'h04;
  localparam logic [7:0] DTAM_OC_PERCENT = 8'd220; // Trip level, percent of rated
  localparam logic [7:0] DTAM_PERCENT_FULL = 8'd100;
  localparam int DTAM_HIST_DEPTH = 6;
  localparam int DTAM_ENTRY_W = 56; // Code, frequency, current, bus voltage
  // Operating phase reported by the speed controller
  typedef enum logic [1:0] {DTAM_PH_CONST, DTAM_PH_DECEL, DTAM_PH_ACCEL, DTAM_PH_OTHER} dtam_phase_t;
endpackage

/* testbench.sv */
// Self-checking testbench of the trip and alarm manager
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dtam_pkg::*;
  // ****************************************
  // Signals and counters
  // ****************************************
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, err_req_i, err_lock_i, stop_key_i;
  logic power_enable_o, alarm_led_o, irq_o;
  logic [7:0] wb_adr_i, err_code_i, multi_input_i, alarm_code_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] out_freq_i, current_sensor_i, dc_bus_i;
  dtam_phase_t phase_i;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  dtam_manager dtam_manager_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .err_req_i(err_req_i), .err_code_i(err_code_i), .err_lock_i(err_lock_i),
    .out_freq_i(out_freq_i), .current_sensor_i(current_sensor_i), .dc_bus_i(dc_bus_i), .phase_i(phase_i),
    .stop_key_i(stop_key_i), .multi_input_i(multi_input_i), .power_enable_o(power_enable_o),
    .alarm_led_o(alarm_led_o), .alarm_code_o(alarm_code_o), .irq_o(irq_o));
  dtam_operator_model dtam_operator_model_inst (.clk_i(clk_i), .stop_key_o(stop_key_i),
    .multi_input_o(multi_input_i));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Classic single Wishbone cycle; entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // Wait for the answer; only the hang guard ends a missing one
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // One-cycle protective error request; lock qualifies it
  task automatic raise_err(input logic [7:0] code, input logic lock);
    err_code_i <= code;
    err_lock_i <= lock;
    err_req_i <= 1'b1;
    @(posedge clk_i);
    err_req_i <= 1'b0;
    err_lock_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Output triple of the trip state
  task automatic chk_trip(input logic tripped, input logic [7:0] code);
    check(power_enable_o, !tripped, "power output");
    check(alarm_led_o, tripped, "alarm indicator");
    check(alarm_code_o, tripped ? code : 8'h00, "alarm code");
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values and an unmapped read
  task automatic s_reset();
    chk_trip(1'b0, 8'h00);
    check(irq_o, 1'b0, "irq at reset");
    wb(1'b0, DTAM_OFS_RATED, 32'h0);
    check(q, 32'h0000FFFF, "rated reset");
    wb(1'b0, DTAM_OFS_IRQ_MASK, 32'h0);
    check(q, 32'h0, "mask reset");
    wb(1'b0, 8'h3C, 32'h0);
    check(q, 32'h0, "unmapped read");
  endtask
  // Trip, snapshot, interrupt, refusal of a second error, key reset
  task automatic s_trip_snapshot();
    wb(1'b1, DTAM_OFS_IRQ_MASK, 32'h1);
    raise_err(8'h21, 1'b0);
    chk_trip(1'b1, 8'h21);
    check(irq_o, 1'b1, "irq on trip");
    raise_err(8'h22, 1'b0);
    check(alarm_code_o, 8'h21, "second error ignored");
    wb(1'b0, DTAM_OFS_SNAP_FREQ, 32'h0);
    check(q, 32'h1234, "snapshot frequency");
    wb(1'b0, DTAM_OFS_SNAP_CUR, 32'h0);
    check(q, 32'h0050, "snapshot current");
    wb(1'b0, DTAM_OFS_SNAP_BUS, 32'h0);
    check(q, 32'h0280, "snapshot bus voltage");
    wb(1'b1, DTAM_OFS_IRQ_STAT, 32'h1);
    check(irq_o, 1'b0, "irq after clear");
    dtam_operator_model_inst.press_key();
    repeat (4) @(posedge clk_i);
    chk_trip(1'b0, 8'h00);
    wb(1'b0, DTAM_OFS_IRQ_STAT, 32'h0);
    check(q, 32'h2, "cleared event");
    wb(1'b1, DTAM_OFS_IRQ_STAT, 32'h3);
  endtask
  // Only the terminal whose function is the reset code clears a trip
  task automatic s_terminal();
    wb(1'b1, DTAM_OFS_FUNC_LO, 32'h0000_0011);
    wb(1'b1, DTAM_OFS_FUNC_HI, 32'h1200_0000);
    raise_err(8'h30, 1'b0);
    dtam_operator_model_inst.pulse_input(0);
    repeat (4) @(posedge clk_i);
    chk_trip(1'b1, 8'h30);
    dtam_operator_model_inst.pulse_input(7);
    repeat (4) @(posedge clk_i);
    chk_trip(1'b0, 8'h00);
  endtask
  // Every stop key selection
  task automatic s_key_select();
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, DTAM_OFS_CONFIG, s);
      raise_err(8'h40 + s, 1'b0);
      dtam_operator_model_inst.press_key();
      repeat (4) @(posedge clk_i);
      chk_trip(s == 1 || s == 3, 8'h40 + s);
      dtam_operator_model_inst.pulse_input(7);
      repeat (4) @(posedge clk_i);
    end
    wb(1'b1, DTAM_OFS_CONFIG, 32'h0);
  endtask
  // Threshold and phase classification of overcurrent
  task automatic s_overcurrent();
    logic [7:0] exp [4];
    exp = '{DTAM_OC_CONST_CODE, DTAM_OC_DECEL_CODE, DTAM_OC_ACCEL_CODE, DTAM_OC_OTHER_CODE};
    wb(1'b1, DTAM_OFS_RATED, 32'd100);
    current_sensor_i <= 16'd219;
    repeat (4) @(posedge clk_i);
    chk_trip(1'b0, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      phase_i <= dtam_phase_t'(p);
      current_sensor_i <= 16'd220;
      repeat (4) @(posedge clk_i);
      chk_trip(1'b1, exp[p]);
      current_sensor_i <= 16'h0050;
      dtam_operator_model_inst.press_key();
      repeat (4) @(posedge clk_i);
    end
    phase_i <= DTAM_PH_CONST;
    wb(1'b1, DTAM_OFS_RATED, 32'h0000FFFF);
  endtask
  // Seven trips: newest first, oldest dropped
  task automatic s_history();
    for (int i = 0; i < 7; i++)
    begin
      out_freq_i <= 16'h0100 + i;
      raise_err(8'h30 + i, 1'b0);
      dtam_operator_model_inst.pulse_input(7);
      repeat (4) @(posedge clk_i);
    end
    for (int k = 0; k < 7; k++)
    begin
      wb(1'b1, DTAM_OFS_HIST_SEL, k);
      repeat (2) @(posedge clk_i);
      wb(1'b0, DTAM_OFS_HIST_A, 32'h0);
      check(q, k < 6 ? {8'h00, 8'h36 - k[7:0], 16'h0106 - k[15:0]} : 32'h0, "history record");
    end
    wb(1'b1, DTAM_OFS_HIST_SEL, 32'h0);
    repeat (2) @(posedge clk_i);
    wb(1'b0, DTAM_OFS_HIST_B, 32'h0);
    check(q, 32'h0050_0280, "history current and bus");
  endtask
  // Locked trip ignores both resets; only a power cycle leaves it
  task automatic s_lock();
    raise_err(8'h50, 1'b1);
    wb(1'b0, DTAM_OFS_STATUS, 32'h0);
    check(q, 32'h0000_5003, "locked status");
    dtam_operator_model_inst.press_key();
    dtam_operator_model_inst.pulse_input(7);
    repeat (4) @(posedge clk_i);
    chk_trip(1'b1, 8'h50);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_trip(1'b0, 8'h00);
    wb(1'b0, DTAM_OFS_HIST_A, 32'h0);
    check(q, 32'h0, "history cleared");
  endtask
  // ****************************************
  // Main sequence and timeout
  // ****************************************
  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, err_req_i, err_lock_i} = 5'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    err_code_i = 8'h00;
    out_freq_i = 16'h1234;
    current_sensor_i = 16'h0050;
    dc_bus_i = 16'h0280;
    phase_i = DTAM_PH_CONST;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_trip_snapshot();
    s_terminal();
    s_key_select();
    s_overcurrent();
    s_history();
    s_lock();
    end_sim();
  end
  // Hang guard, well above the few hundred cycles of the run
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
endmodule // testbench
`default_nettype wire
